// >>> design/lcd_map.vh
/*
  Command codes, the column limit, reset values and timing counts for the
  LCD command decoder. Assumes inclusion by bare name from design files.
*/
`ifndef LCD_MAP_VH
`define LCD_MAP_VH
`define LCD_CMD_VOL_MODE 8'h81
`define LCD_CMD_RMW 8'hE0
`define LCD_CMD_END 8'hEE
`define LCD_CMD_RESET 8'hE2
`define LCD_CMD_NOP 8'hE3
`define LCD_VOL_RESET 6'h20
`define LCD_COL_MAX 8'h83
`define LCD_CLK_HZ 250000000
`define LCD_BLINK_SLOW_MS 1000
`define LCD_BLINK_FAST_MS 500
`define LCD_BLINK_SLOW_CYC (`LCD_CLK_HZ / 1000 * `LCD_BLINK_SLOW_MS)
`define LCD_BLINK_FAST_CYC (`LCD_CLK_HZ / 1000 * `LCD_BLINK_FAST_MS)
`define LCD_RESET_BUSY_CYC 3'h4
`endif

// >>> design/lcd_sync2.v
/*
  Two-flop synchroniser for pin inputs, one bit per lane.
  Assumes mclk and an asynchronous active-low reset.
*/
`timescale 1ns/100ps
module lcd_sync2 #(
  parameter W = 1,
  parameter [W-1:0] RST_VAL = {W{1'b0}}
) (
  // Clock and reset
  input wire mclk,
  input wire rst_b,
  // Data
  input wire [W-1:0] d,
  output reg [W-1:0] q
);
  reg [W-1:0] meta;

  always @(posedge mclk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      // Reset to the idle pin level so no false strobe edge follows reset
      meta <= RST_VAL;
      q <= RST_VAL;
    end
    else
    begin
      meta <= d;
      q <= meta;
    end
  end
endmodule // lcd_sync2

// >>> design/lcd_cmd_dec.v
/*
  Command decoder of a dot-matrix LCD driver: host bus strobes, command
  state, power save, indicator blink and read/modify/write addressing.
  Assumes host strobes and bus pins are asynchronous to mclk; RAM array
  is outside and reached through the ram_* ports.
*/
`timescale 1ns/100ps
`include "lcd_map.vh"
module lcd_cmd_dec #(
  parameter BLINK_SLOW = `LCD_BLINK_SLOW_CYC,
  parameter BLINK_FAST = `LCD_BLINK_FAST_CYC
) (
  // Clock and reset
  input wire mclk,
  input wire rst_b,
  input wire hw_reset_n,
  // Host bus pins
  input wire cmd_data_select,
  input wire wr_n,
  input wire rd_n,
  input wire [7:0] db_in,
  output reg [7:0] db_out,
  output reg db_oe,
  // Display RAM port
  output reg ram_wr,
  output reg ram_rd,
  output reg [7:0] ram_wdata,
  output reg [3:0] ram_page,
  output reg [7:0] ram_col,
  input wire [7:0] ram_rdata,
  // Settings
  output reg display_on,
  output reg [5:0] start_line,
  output reg seg_reverse,
  output reg bias_sel,
  output reg all_points_on,
  output reg polarity_reverse,
  output reg [2:0] com_mode,
  output reg booster_en,
  output reg regulator_en,
  output reg follower_en,
  output reg [2:0] regulator_resistor_ratio,
  output reg [5:0] drive_level,
  // Power save, indicator, test mode and busy
  output reg sleep_mode,
  output reg standby_mode,
  output reg osc_run,
  output reg drive_halt,
  output reg display_blank_n,
  output reg indicator_drive_a,
  output reg indicator_drive_b,
  output reg test_mode,
  output reg busy
);
  localparam ST_IDLE = 2'd0;
  localparam ST_VOL = 2'd1;
  localparam ST_IND = 2'd2;

  wire [11:0] pin_s;
  wire sel_s;
  wire wr_s_n;
  wire rd_s_n;
  wire hwr_s_n;
  wire [7:0] db_s;
  reg wr_d_n;
  reg rd_d_n;
  reg [1:0] state;
  reg ind_on;
  reg [1:0] ind_mode;
  reg rmw;
  reg [7:0] rmw_col;
  reg [31:0] blink_cnt;
  reg blink;
  reg [2:0] rst_cnt;
  wire wr_pulse;
  wire rd_pulse;
  wire save;
  wire [7:0] col_inc;
  wire [31:0] blink_lim;

  // Pins cross into mclk first
  lcd_sync2 #(.W(12), .RST_VAL(12'hB00)) u_sync (
    .mclk(mclk),
    .rst_b(rst_b),
    .d({hw_reset_n, cmd_data_select, wr_n, rd_n, db_in}),
    .q(pin_s)
  );
  assign hwr_s_n = pin_s[11];
  assign sel_s = pin_s[10];
  assign wr_s_n = pin_s[9];
  assign rd_s_n = pin_s[8];
  assign db_s = pin_s[7:0];

  // Write data latched on rising wr_n edge, as the bus does; read data on falling rd_n edge
  assign wr_pulse = wr_s_n & ~wr_d_n;
  assign rd_pulse = ~rd_s_n & rd_d_n;
  assign save = sleep_mode | standby_mode;
  assign col_inc = (ram_col == `LCD_COL_MAX) ? ram_col : ram_col + 8'h01;
  assign blink_lim = (ind_mode == 2'b01) ? BLINK_SLOW : BLINK_FAST;

  always @(posedge mclk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      wr_d_n <= 1'b1;
      rd_d_n <= 1'b1;
      state <= ST_IDLE;
      db_out <= 8'h00;
      db_oe <= 1'b0;
      ram_wr <= 1'b0;
      ram_rd <= 1'b0;
      ram_wdata <= 8'h00;
      ram_page <= 4'h0;
      ram_col <= 8'h00;
      display_on <= 1'b0;
      start_line <= 6'h00;
      seg_reverse <= 1'b0;
      bias_sel <= 1'b0;
      all_points_on <= 1'b0;
      polarity_reverse <= 1'b0;
      com_mode <= 3'h0;
      booster_en <= 1'b0;
      regulator_en <= 1'b0;
      follower_en <= 1'b0;
      regulator_resistor_ratio <= 3'h0;
      drive_level <= `LCD_VOL_RESET;
      sleep_mode <= 1'b0;
      standby_mode <= 1'b0;
      osc_run <= 1'b1;
      drive_halt <= 1'b0;
      display_blank_n <= 1'b1;
      test_mode <= 1'b0;
      ind_on <= 1'b0;
      ind_mode <= 2'b00;
      rmw <= 1'b0;
      rmw_col <= 8'h00;
      rst_cnt <= 3'h0;
      busy <= 1'b0;
    end
    else
    begin
      wr_d_n <= wr_s_n;
      rd_d_n <= rd_s_n;
      ram_wr <= 1'b0;
      ram_rd <= 1'b0;
      db_oe <= ~rd_s_n;
      osc_run <= ~sleep_mode;
      drive_halt <= save;
      display_blank_n <= ~save;
      if (rst_cnt != 3'h0)
        rst_cnt <= rst_cnt - 3'h1;
      busy <= (rst_cnt != 3'h0);
      if (!hwr_s_n)
      begin
        // Pin reset brings back every setting and leaves power save
        test_mode <= 1'b0;
        state <= ST_IDLE;
        display_on <= 1'b0;
        start_line <= 6'h00;
        seg_reverse <= 1'b0;
        bias_sel <= 1'b0;
        all_points_on <= 1'b0;
        polarity_reverse <= 1'b0;
        com_mode <= 3'h0;
        booster_en <= 1'b0;
        regulator_en <= 1'b0;
        follower_en <= 1'b0;
        regulator_resistor_ratio <= 3'h0;
        drive_level <= `LCD_VOL_RESET;
        sleep_mode <= 1'b0;
        standby_mode <= 1'b0;
        ind_on <= 1'b0;
        ind_mode <= 2'b00;
        rmw <= 1'b0;
        ram_page <= 4'h0;
        ram_col <= 8'h00;
        rst_cnt <= `LCD_RESET_BUSY_CYC;
      end
      else if (rd_pulse)
      begin
        if (sel_s)
        begin
          db_out <= ram_rdata;
          ram_rd <= 1'b1;
          if (!rmw)
            ram_col <= col_inc;
        end
        else
          db_out <= {busy, ~seg_reverse, ~display_on, busy, 4'h0};
      end
      else if (wr_pulse && sel_s)
      begin
        ram_wr <= 1'b1;
        ram_wdata <= db_s;
        ram_col <= col_inc;
      end
      else if (wr_pulse)
      begin
        case (state)
          ST_VOL:
          begin
            drive_level <= db_s[5:0];
            state <= ST_IDLE;
          end
          ST_IND:
          begin
            ind_mode <= db_s[1:0];
            state <= ST_IDLE;
          end
          default:
          begin
            if (db_s[7:4] == 4'hF)
              test_mode <= 1'b1;
            else if (db_s == `LCD_CMD_NOP)
              test_mode <= 1'b0;
            else if (db_s == `LCD_CMD_RESET)
            begin
              test_mode <= 1'b0;
              start_line <= 6'h00;
              ram_page <= 4'h0;
              ram_col <= 8'h00;
              com_mode <= 3'h0;
              regulator_resistor_ratio <= 3'h0;
              drive_level <= `LCD_VOL_RESET;
              ind_on <= 1'b0;
              ind_mode <= 2'b00;
              rmw <= 1'b0;
              rst_cnt <= `LCD_RESET_BUSY_CYC;
              if (standby_mode)
              begin
                standby_mode <= 1'b0;
                sleep_mode <= 1'b1;
              end
            end
            else if (db_s == `LCD_CMD_VOL_MODE)
              state <= ST_VOL;
            else if (db_s == `LCD_CMD_RMW)
            begin
              rmw <= 1'b1;
              rmw_col <= ram_col;
            end
            else if (db_s == `LCD_CMD_END)
            begin
              if (rmw)
                ram_col <= rmw_col;
              rmw <= 1'b0;
            end
            else if (db_s[7:1] == 7'b1010110)
            begin
              ind_on <= db_s[0];
              if (db_s[0])
                state <= ST_IND;
              else
                ind_mode <= 2'b00;
            end
            else if (db_s[7:1] == 7'b1010111)
            begin
              display_on <= db_s[0];
              if (!db_s[0] && all_points_on)
              begin
                sleep_mode <= ~ind_on;
                standby_mode <= ind_on;
              end
              else if (db_s[0])
              begin
                sleep_mode <= 1'b0;
                standby_mode <= 1'b0;
              end
            end
            else if (db_s[7:2] == 6'b101000)
            begin
              if (db_s[1])
                bias_sel <= db_s[0];
              else
                seg_reverse <= db_s[0];
            end
            else if (db_s[7:2] == 6'b101001)
            begin
              if (db_s[1])
                polarity_reverse <= db_s[0];
              else
              begin
                all_points_on <= db_s[0];
                if (db_s[0] && !display_on)
                begin
                  sleep_mode <= ~ind_on;
                  standby_mode <= ind_on;
                end
                else if (!db_s[0])
                begin
                  sleep_mode <= 1'b0;
                  standby_mode <= 1'b0;
                end
              end
            end
            else if (db_s[7:6] == 2'b01)
              start_line <= db_s[5:0];
            else if (db_s[7:4] == 4'hB)
              ram_page <= db_s[3:0];
            else if (db_s[7:4] == 4'h1)
              ram_col <= {db_s[3:0], ram_col[3:0]};
            else if (db_s[7:4] == 4'h0)
              ram_col <= {ram_col[7:4], db_s[3:0]};
            else if (db_s[7:3] == 5'b00101)
            begin
              booster_en <= db_s[2];
              regulator_en <= db_s[1];
              follower_en <= db_s[0];
            end
            else if (db_s[7:3] == 5'b00100)
              regulator_resistor_ratio <= db_s[2:0];
            else if (db_s[7:4] == 4'hC)
              com_mode <= {2'b00, db_s[3]}; // Only bit 3 is live; low bits are don't-care
          end
        endcase
      end
    end
  end

  // Blink timer runs only while the oscillator runs; cleared to zero in sleep
  always @(posedge mclk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      blink_cnt <= 32'h0;
      blink <= 1'b0;
      indicator_drive_a <= 1'b0;
      indicator_drive_b <= 1'b0;
    end
    else
    begin
      if (sleep_mode || ind_mode == 2'b00 || ind_mode == 2'b11)
        blink_cnt <= 32'h0;
      else if (blink_cnt >= blink_lim - 32'h1)
      begin
        blink_cnt <= 32'h0;
        blink <= ~blink;
      end
      else
        blink_cnt <= blink_cnt + 32'h1;
      indicator_drive_a <= 1'b0;
      indicator_drive_b <= ~sleep_mode & ind_on &
        ((ind_mode == 2'b11) | (ind_mode[0] ^ ind_mode[1]) & blink);
    end
  end
endmodule // lcd_cmd_dec

// >>> tb/lcd_cmd_dec_asserts.sv
/*
  Port checker for the LCD command decoder.
  Assumes one clock domain and binding onto lcd_cmd_dec.
*/
`timescale 1ns/100ps
module lcd_cmd_dec_asserts (
  // Clock and reset
  input wire mclk,
  input wire rst_b,
  // Host strobes, bus enable and RAM write
  input wire wr_n,
  input wire rd_n,
  input wire ram_wr,
  input wire db_oe,
  // Display and power save
  input wire display_on,
  input wire all_points_on,
  input wire sleep_mode,
  input wire standby_mode,
  input wire osc_run,
  input wire drive_halt,
  input wire display_blank_n
);
  default clocking cb @(posedge mclk);
  endclocking
  default disable iff (!rst_b);
  wire saving = sleep_mode || standby_mode;
  // Two cycles allow for the blanking flop lagging the mode flops
  chk_blank_low: assert property (saving [*2] |-> !display_blank_n)
    else $error("blanking high in power save");
  chk_blank_high: assert property (!saving [*2] |-> display_blank_n)
    else $error("blanking low outside power save");
  chk_save_cause: assert property ($rose(saving) |-> !display_on && all_points_on)
    else $error("power save without its cause");
  chk_mode_excl: assert property (!(sleep_mode && standby_mode))
    else $error("sleep and standby together");
  chk_sleep_off: assert property (sleep_mode [*2] |-> !osc_run && drive_halt)
    else $error("oscillator running in sleep");
  chk_standby_run: assert property (standby_mode [*2] |-> osc_run && drive_halt)
    else $error("standby drive state wrong");
  chk_wr_pulse: assert property (ram_wr |-> $past(wr_n) && $past(wr_n, 2))
    else $error("RAM write before strobe rise");
  chk_oe_read: assert property ($rose(db_oe) |-> !rd_n && !$past(rd_n, 2))
    else $error("bus driven without read");
  cover property ($rose(sleep_mode));
  cover property ($rose(standby_mode));
  cover property ($rose(db_oe));
endmodule // lcd_cmd_dec_asserts

bind lcd_cmd_dec lcd_cmd_dec_asserts i_chk (
  .mclk, .rst_b, .wr_n, .rd_n, .ram_wr, .db_oe, .display_on, .all_points_on,
  .sleep_mode, .standby_mode, .osc_run, .drive_halt, .display_blank_n
);

// >>> tb/lcd_host.sv
/*
  Host processor model on the 8-bit parallel bus.
  Assumes the bench calls wr and rd one at a time.
*/
`timescale 1ns/100ps
module lcd_host (
  // Clock
  input wire mclk,
  // Host bus
  output logic cmd_data_select,
  output logic wr_n,
  output logic rd_n,
  output logic [7:0] db_in,
  input wire [7:0] db_out
);
  initial
  begin
    cmd_data_select = 1'b0;
    wr_n = 1'b1;
    rd_n = 1'b1;
    db_in = 8'h00;
  end
  task automatic wr(input logic sel, input logic [7:0] d);
    @(negedge mclk);
    cmd_data_select = sel;
    db_in = d;
    wr_n = 1'b0;
    repeat (4) @(negedge mclk);
    wr_n = 1'b1;
    // Data is taken after sync, so it must outlive the rise
    repeat (3) @(negedge mclk);
    db_in = ~d;
    repeat (4) @(negedge mclk);
  endtask
  task automatic rd(input logic sel, output logic [7:0] q);
    @(negedge mclk);
    cmd_data_select = sel;
    rd_n = 1'b0;
    repeat (6) @(negedge mclk);
    q = db_out;
    rd_n = 1'b1;
    repeat (4) @(negedge mclk);
  endtask
endmodule // lcd_host

// >>> tb/testbench.sv
/*
  Self-checking bench for lcd_cmd_dec driven by the host model.
  Assumes the checker is bound and blink counts are shortened.
*/
`timescale 1ns/100ps
`define CHK(n, e, g) \
  begin \
    tests_run++; \
    if ((g) !== (e)) \
    begin \
      fails++; \
      $display("ERROR %s expected %0h seen %0h", n, e, g); \
    end \
  end
module testbench;
  logic mclk = 1'b0;
  logic rst_b = 1'b0;
  logic hw_reset_n = 1'b1;
  int fails = 0;
  int tests_run = 0;
  int wcnt = 0;
  int rcnt = 0;
  logic [7:0] last_wdata = 8'h00;
  wire cmd_data_select, wr_n, rd_n, ram_wr, display_on, seg_reverse, bias_sel;
  wire all_points_on, polarity_reverse, booster_en, regulator_en, follower_en;
  wire sleep_mode, standby_mode, osc_run, drive_halt, display_blank_n;
  wire indicator_drive_b, test_mode, busy, ram_rd;
  wire [7:0] db_in, db_out, ram_wdata, ram_col, ram_rdata;
  wire [3:0] ram_page;
  wire [5:0] start_line, drive_level;
  wire [2:0] regulator_resistor_ratio;
  // RAM stand-in returns its page and low column nibble so reads can be checked
  assign ram_rdata = {ram_page, ram_col[3:0]};
  lcd_cmd_dec #(
    .BLINK_SLOW(20),
    .BLINK_FAST(10)
  ) i_lcd_cmd_dec (
    .mclk, .rst_b, .hw_reset_n, .cmd_data_select, .wr_n, .rd_n, .db_in, .db_out,
    .db_oe(), .ram_wr, .ram_rd, .ram_wdata, .ram_page, .ram_col, .ram_rdata,
    .display_on, .start_line, .seg_reverse, .bias_sel, .all_points_on,
    .polarity_reverse, .com_mode(), .booster_en, .regulator_en, .follower_en,
    .regulator_resistor_ratio, .drive_level, .sleep_mode, .standby_mode, .osc_run,
    .drive_halt, .display_blank_n, .indicator_drive_a(), .indicator_drive_b,
    .test_mode, .busy
  );
  lcd_host i_lcd_host (
    .mclk, .cmd_data_select, .wr_n, .rd_n, .db_in, .db_out
  );
  initial
  begin
    forever #2 mclk = ~mclk;
  end
  always @(posedge mclk)
  begin
    if (ram_wr)
    begin
      last_wdata <= ram_wdata;
      wcnt <= wcnt + 1;
    end
    if (ram_rd)
      rcnt <= rcnt + 1;
  end
  task automatic cmd(input logic [7:0] d);
    i_lcd_host.wr(1'b0, d);
  endtask
  task automatic finish_test();
    $display("Checks %0d mismatches %0d", tests_run, fails);
    if (fails == 0 && tests_run > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask
  task automatic wait_idle();
    int i;
    for (i = 0; i < 50 && busy !== 1'b0; i++)
      @(negedge mclk);
    if (i == 50)
    begin
      fails++;
      finish_test();
    end
  endtask
  task automatic t_power();
    for (int i = 0; i < 8; i++)
    begin
      cmd(8'h28 | 8'(i));
      `CHK("supply_en", 3'(i), {booster_en, regulator_en, follower_en})
      cmd(8'h20 | 8'(i));
      `CHK("ratio", 3'(i), regulator_resistor_ratio)
    end
  endtask
  task automatic t_volume();
    `CHK("level_rst", 6'h20, drive_level)
    cmd(8'h81);
    cmd(8'hF7);
    `CHK("level", 6'h37, drive_level)
    `CHK("no_test", 1'b0, test_mode)
    cmd(8'h25);
    `CHK("after_vol", {3'h5, 6'h37}, {regulator_resistor_ratio, drive_level})
    cmd(8'h81);
    cmd(8'hA0);
    `CHK("level_unused", 6'h20, drive_level)
  endtask
  task automatic t_addr();
    logic [7:0] q;
    cmd(8'h7F);
    `CHK("start_line", 6'h3F, start_line)
    cmd(8'hB8);
    `CHK("page", 4'h8, ram_page)
    cmd(8'h11);
    cmd(8'h02);
    `CHK("column", 8'h12, ram_col)
    cmd(8'hE0);
    i_lcd_host.rd(1'b1, q);
    `CHK("ram_read", 8'h82, q)
    `CHK("ram_rd", 1, rcnt)
    `CHK("rmw_rd_col", 8'h12, ram_col)
    i_lcd_host.wr(1'b1, 8'h5A);
    `CHK("wdata", 8'h5A, last_wdata)
    `CHK("rmw_wr_col", 8'h13, ram_col)
    cmd(8'hEE);
    `CHK("end_col", 8'h12, ram_col)
  endtask
  task automatic t_bits();
    logic [3:0] f;
    logic [7:0] q;
    for (int k = 0; k < 4; k++)
      for (int v = 0; v < 2; v++)
      begin
        cmd(8'hA0 | 8'(2 * k + v));
        f = {seg_reverse, bias_sel, all_points_on, polarity_reverse};
        `CHK("mode_bit", 1'(v), f[3 - k])
      end
    cmd(8'hAF);
    `CHK("display_on", 1'b1, display_on)
    i_lcd_host.rd(1'b0, q);
    `CHK("status", 8'h00, q)
    `CHK("status_rd", 1, rcnt)
    cmd(8'hAE);
    `CHK("display_off", 1'b0, display_on)
    `CHK("off_save", 1'b1, sleep_mode)
    i_lcd_host.rd(1'b0, q);
    `CHK("status_off", 8'h20, q)
  endtask
  task automatic t_save();
    int n;
    cmd(8'hA4);
    `CHK("awake", 1'b0, sleep_mode)
    cmd(8'hAC);
    cmd(8'hA5);
    `CHK("sleep", 3'b100, {sleep_mode, standby_mode, osc_run})
    `CHK("blank_n", 1'b0, display_blank_n)
    n = wcnt;
    i_lcd_host.wr(1'b1, 8'hC3);
    `CHK("save_write", n + 1, wcnt)
    `CHK("kept_level", 6'h20, drive_level)
    cmd(8'hA4);
    `CHK("wake", 2'b01, {sleep_mode, display_blank_n})
    cmd(8'hAD);
    cmd(8'h03);
    cmd(8'hA5);
    `CHK("standby", 4'b0111, {sleep_mode, standby_mode, osc_run, drive_halt})
    cmd(8'hE2);
    wait_idle();
    `CHK("to_sleep", 2'b10, {sleep_mode, standby_mode})
    cmd(8'hA4);
  endtask
  task automatic t_indicator();
    int tgl [4] = '{0, 3, 6, 0};
    int cnt;
    logic prev;
    for (int m = 0; m < 4; m++)
    begin
      cmd(8'hAD);
      cmd(8'hFC | 8'(m));
      cnt = 0;
      prev = indicator_drive_b;
      repeat (60)
      begin
        @(negedge mclk);
        if (indicator_drive_b !== prev)
          cnt++;
        prev = indicator_drive_b;
      end
      `CHK("blink", 1'b1, cnt >= tgl[m] - 1 && cnt <= tgl[m])
    end
    `CHK("steady", 1'b1, indicator_drive_b)
    cmd(8'hAC);
    `CHK("ind_off", 1'b0, indicator_drive_b)
  endtask
  task automatic t_test();
    cmd(8'hF5);
    `CHK("test_on", 1'b1, test_mode)
    cmd(8'hE3);
    `CHK("nop_clear", 1'b0, test_mode)
    cmd(8'hFA);
    cmd(8'hE2);
    wait_idle();
    `CHK("cmd_clear", 1'b0, test_mode)
    cmd(8'hF0);
    hw_reset_n = 1'b0;
    repeat (4) @(negedge mclk);
    hw_reset_n = 1'b1;
    repeat (3) @(negedge mclk);
    wait_idle();
    `CHK("pin_clear", 1'b0, test_mode)
  endtask
  initial
  begin
    #100000;
    fails++;
    finish_test();
  end
  initial
  begin
    repeat (8) @(negedge mclk);
    rst_b = 1'b1;
    t_power();
    t_volume();
    t_addr();
    t_bits();
    t_save();
    t_indicator();
    t_test();
    finish_test();
  end
endmodule // testbench
